// [core/sleep_ctrl_map.vh]
/*
  Constants of the sleep-mode power controller: mode codes, wake bit
  positions, clock gate bit positions and timing figures.
  Assumes a 100 MHz core clock; included by its bare name.
*/
`ifndef SLEEP_CTRL_MAP_VH
`define SLEEP_CTRL_MAP_VH

// sleep_kind_field codes
`define MODE_IDLE 3'h0
`define MODE_NOISE 3'h1
`define MODE_PDOWN 3'h2
`define MODE_PSAVE 3'h3
`define MODE_RSVD4 3'h4
`define MODE_RSVD5 3'h5
`define MODE_STBY 3'h6
`define MODE_XSTBY 3'h7

// wakeIrq bit positions
`define WK_EXT_EDGE 0
`define WK_PIN_CHANGE 1
`define WK_TWI_MATCH 2
`define WK_TIMER2 3
`define WK_NVM_READY 4
`define WK_ADC 5
`define WK_WDT 6
`define WK_SER_START 7
`define WK_SER_OTHER 8
`define WK_OTHER_IO 9
`define WK_WIDTH 10

// clkEnable bit positions
`define CK_CORE 0
`define CK_FLASH 1
`define CK_IO 2
`define CK_ADC 3
`define CK_ASYNC 4
`define CK_TOUCH 5
`define CK_MAIN_OSC 6
`define CK_TIMER_OSC 7
`define CK_WIDTH 8

// timing
`define CLK_PERIOD_NS 10
`define HALT_CYC 4
`define STBY_WAKE_CYC 6
`define BOD_WAKE_NS 60000
`define BROWNOUT_SLEEP_OFF_BIT_WINDOW_CYC 4
`define STARTUP_CYC_DFLT 16

`endif

// [core/sleep_mode_power_controller.v]
/*
  Sleep-mode power controller: takes the core's sleep instruction, gates
  clock domains and oscillators per mode, watches wake sources, sequences
  wake-up and controls the brown-out detector during sleep.
  Assumes the core stalls while coreStall is high and that the pin inputs
  extIrqPinA/B arrive asynchronously; all other inputs are on core_clk.
*/
// Overview of operation
// - mode 000 is idle; core and flash clocks stop, and timer oscillator too unless timer 2 runs asynchronously.
// - idle keeps peripherals, converter, timers, watchdog, interrupts running.
// - idle wakes on external and internal interrupts.
// - converter enabled and its clock kept: conversion starts at sleep entry.
// - each mode gates clock domains and oscillators per its table.
// - each mode has its own set of accepted wake sources.
// - outside idle, external irq pins wake only by level, never edge.
// - outside idle, serial port wakes only by start frame detection.
// - timer oscillator, and timer 2 wake outside idle, only when timer 2 runs asynchronously.
// - power-save keeps main clock source while touch controller is enabled.
// - on interrupt wake, stall four cycles beyond start-up, then run handler.
// - register file and SRAM kept across sleep and wake-up.
// - reset during sleep wakes to the reset vector.
// - brown-out detector off during deep sleep if requested, back on at wake.
// - wake-up stretched to about 60 us when detector was off.
// - brown-out sleep off bit: 1 disables, 0 keeps detector; resets to 0.
// - that bit is written only through a timed enable sequence.
// - codes 001, 010, 011 select noise-reduction, power-down, power-save.
// - codes 110, 111 select standby modes only with crystal clock source.
// - wake from standby modes takes six cycles.
`timescale 1ns/100ps
`include "sleep_ctrl_map.vh"

module sleep_mode_power_controller #(
  parameter STARTUP_CYC = `STARTUP_CYC_DFLT,
  parameter BOD_WAKE_CYC = (`BOD_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter CNT_W = 16
) (
  input wire core_clk,
  input wire nrst,
  input wire sleepInstr,
  input wire sleepEnableBit,
  input wire [2:0] sleepKindField,
  input wire crystalSelected,
  input wire adcEnabled,
  input wire timer2Async,
  input wire touchEnabled,
  input wire brownoutFusesOn,
  input wire bodsWrStb,
  input wire bodsWrData,
  input wire bodsEnWrData,
  input wire extIrqPinA,
  input wire extIrqPinB,
  input wire [1:0] extLevelMode,
  input wire [`WK_WIDTH-1:0] wakeIrq,
  input wire sysResetReq,
  output reg [`CK_WIDTH-1:0] clkEnable,
  output reg brownoutEn,
  output reg brownoutSleepOffBit,
  output reg adcAutoStart,
  output wire coreStall,
  output reg resumeIrq,
  output reg resumeReset,
  output reg sleeping,
  output reg [2:0] activeMode
);

  localparam ST_ACTIVE = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_START = 2'h2;
  localparam ST_HALT = 2'h3;
  // counts kept as integers so every use cuts them to width on purpose
  localparam integer HALT_LEN = `HALT_CYC, STBY_LEN = `STBY_WAKE_CYC, WIN_LEN = `BROWNOUT_SLEEP_OFF_BIT_WINDOW_CYC;

  // clock domains left running in each mode
  function [`CK_WIDTH-1:0] gateVec;
    input [2:0] mode;
    input t2a;
    input touch;
    begin
      gateVec = {`CK_WIDTH{1'b0}};
      case (mode)
        `MODE_IDLE: begin
          gateVec = {`CK_WIDTH{1'b1}};
          gateVec[`CK_CORE] = 1'b0;
          gateVec[`CK_FLASH] = 1'b0;
          gateVec[`CK_TIMER_OSC] = t2a;
        end
        `MODE_NOISE: begin
          gateVec[`CK_ADC] = 1'b1;
          gateVec[`CK_ASYNC] = 1'b1;
          gateVec[`CK_TOUCH] = 1'b1;
          gateVec[`CK_MAIN_OSC] = 1'b1;
          gateVec[`CK_TIMER_OSC] = t2a;
        end
        `MODE_PSAVE: begin
          gateVec[`CK_ASYNC] = 1'b1;
          gateVec[`CK_TOUCH] = 1'b1;
          gateVec[`CK_MAIN_OSC] = touch;
          gateVec[`CK_TIMER_OSC] = t2a;
        end
        `MODE_STBY: begin
          gateVec[`CK_MAIN_OSC] = 1'b1;
        end
        `MODE_XSTBY: begin
          gateVec[`CK_ASYNC] = t2a;
          gateVec[`CK_TOUCH] = 1'b1;
          gateVec[`CK_MAIN_OSC] = 1'b1;
          gateVec[`CK_TIMER_OSC] = t2a;
        end
        default: gateVec = {`CK_WIDTH{1'b0}}; // power-down stops all
      endcase
    end
  endfunction

  // wake sources accepted in each mode
  function [`WK_WIDTH-1:0] wakeMask;
    input [2:0] mode;
    input t2a;
    begin
      wakeMask = {`WK_WIDTH{1'b0}};
      // common to every mode; outside idle no edge, no other serial events
      wakeMask[`WK_PIN_CHANGE] = 1'b1;
      wakeMask[`WK_TWI_MATCH] = 1'b1;
      wakeMask[`WK_WDT] = 1'b1;
      wakeMask[`WK_SER_START] = 1'b1;
      case (mode)
        `MODE_IDLE: wakeMask = {`WK_WIDTH{1'b1}};
        `MODE_NOISE: begin
          wakeMask[`WK_TIMER2] = t2a;
          wakeMask[`WK_NVM_READY] = 1'b1;
          wakeMask[`WK_ADC] = 1'b1;
        end
        `MODE_PSAVE, `MODE_XSTBY: wakeMask[`WK_TIMER2] = t2a;
        default: wakeMask[`WK_TIMER2] = 1'b0; // power-down, standby
      endcase
    end
  endfunction

  // mode codes that actually enter sleep
  function modeOk;
    input [2:0] mode;
    input xtal;
    begin
      case (mode)
        `MODE_IDLE, `MODE_NOISE, `MODE_PDOWN, `MODE_PSAVE: modeOk = 1'b1;
        `MODE_STBY, `MODE_XSTBY: modeOk = xtal;
        default: modeOk = 1'b0;
      endcase
    end
  endfunction

  // modes where the detector may be switched off
  function bodOffOk;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_PDOWN, `MODE_PSAVE, `MODE_STBY, `MODE_XSTBY: bodOffOk = 1'b1;
        default: bodOffOk = 1'b0;
      endcase
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] mode_r;
  reg bodOff_r;
  reg resetWake_r;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg [CNT_W-1:0] wakeLen;
  reg [2:0] bodsWin_r;
  wire [1:0] pinRaw;
  wire [1:0] pinLow;
  wire [`WK_WIDTH-1:0] mask;
  wire levelWake;
  wire wakeNow;
  wire sleepGo;

  assign pinRaw = {extIrqPinB, extIrqPinA};

  // three-stage pin synchronisers; level counts once stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : pinSync
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      always @(posedge core_clk) begin
        if (!nrst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          lvl_r <= 1'b1;
        end else begin
          s1_r <= pinRaw[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign pinLow[gi] = ~lvl_r & extLevelMode[gi];
    end
  endgenerate

  assign mask = wakeMask(mode_r, timer2Async);
  assign levelWake = |pinLow;
  assign wakeNow = levelWake | (|(wakeIrq & mask));
  // a sleep with the enable bit clear or a bad code is a no-op
  assign sleepGo = sleepInstr & sleepEnableBit & modeOk(sleepKindField, crystalSelected);
  assign coreStall = (state_r != ST_ACTIVE);

  // wake length: start-up time, six cycles for standby, stretched for detector
  always @* begin
    case (mode_r)
      `MODE_IDLE: wakeLen = {{(CNT_W-1){1'b0}}, 1'b1};
      `MODE_STBY, `MODE_XSTBY: wakeLen = STBY_LEN[CNT_W-1:0];
      default: wakeLen = STARTUP_CYC[CNT_W-1:0];
    endcase
    if (bodOff_r && (wakeLen < BOD_WAKE_CYC[CNT_W-1:0])) begin
      wakeLen = BOD_WAKE_CYC[CNT_W-1:0];
    end
  end

  // sleep sequencer next state
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_ACTIVE: begin
        if (sleepGo) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (sysResetReq || wakeNow) begin
          state_nxt = ST_START;
          cnt_nxt = wakeLen;
        end
      end
      ST_START: begin
        if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          if (resetWake_r) begin
            state_nxt = ST_ACTIVE;
          end else begin
            state_nxt = ST_HALT;
            cnt_nxt = HALT_LEN[CNT_W-1:0];
          end
        end else begin
          cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_HALT: begin
        if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          state_nxt = ST_ACTIVE;
        end else begin
          cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  // sequencer registers; core state itself is never touched here
  always @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= ST_ACTIVE;
      cnt_r <= {CNT_W{1'b0}};
      mode_r <= `MODE_IDLE;
      bodOff_r <= 1'b0;
      resetWake_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (state_r == ST_ACTIVE && sleepGo) begin
        mode_r <= sleepKindField;
        bodOff_r <= brownoutSleepOffBit & brownoutFusesOn & bodOffOk(sleepKindField);
        resetWake_r <= 1'b0;
      end else if (state_r == ST_SLEEP && sysResetReq) begin
        resetWake_r <= 1'b1;
      end
    end
  end

  // registered outputs; clkEnable and brownoutEn one cycle behind the state
  always @(posedge core_clk) begin
    if (!nrst) begin
      clkEnable <= {`CK_WIDTH{1'b1}};
      brownoutEn <= 1'b1;
      adcAutoStart <= 1'b0;
      resumeIrq <= 1'b0;
      resumeReset <= 1'b0;
      sleeping <= 1'b0;
      activeMode <= `MODE_IDLE;
    end else begin
      if (state_r == ST_SLEEP) begin
        clkEnable <= gateVec(mode_r, timer2Async, touchEnabled);
      end else begin
        clkEnable <= {`CK_WIDTH{1'b1}};
      end
      brownoutEn <= ~(state_r == ST_SLEEP && bodOff_r);
      // converter clock runs only in idle and noise reduction
      adcAutoStart <= sleepGo & (state_r == ST_ACTIVE) & adcEnabled &
        (sleepKindField == `MODE_IDLE || sleepKindField == `MODE_NOISE);
      resumeIrq <= (state_r == ST_HALT) && (state_nxt == ST_ACTIVE);
      resumeReset <= (state_r == ST_START) && (state_nxt == ST_ACTIVE);
      sleeping <= (state_nxt == ST_SLEEP);
      activeMode <= (state_r == ST_ACTIVE && sleepGo) ? sleepKindField : mode_r; // with sleeping
    end
  end

  // timed write of the brown-out sleep off bit: arm, then write within window
  always @(posedge core_clk) begin
    if (!nrst) begin
      brownoutSleepOffBit <= 1'b0;
      bodsWin_r <= 3'h0;
    end else begin
      if (bodsWrStb && bodsEnWrData && bodsWrData) begin
        bodsWin_r <= WIN_LEN[2:0];
      end else if (bodsWrStb && !bodsEnWrData && bodsWin_r != 3'h0) begin
        brownoutSleepOffBit <= bodsWrData;
        bodsWin_r <= 3'h0;
      end else if (bodsWin_r != 3'h0) begin
        bodsWin_r <= bodsWin_r - 3'h1;
      end
    end
  end

endmodule

// [bench/sleep_ctrl_chk.sv]
/* port checker of the sleep controller
   bound into the sleep controller module; one clock, synchronous reset */
`timescale 1ns/100ps
module sleep_ctrl_chk (
  input wire core_clk,
  input wire nrst,
  input wire sleepInstr,
  input wire sleepEnableBit,
  input wire [2:0] sleepKindField,
  input wire adcEnabled,
  input wire bodsWrStb,
  input wire bodsWrData,
  input wire bodsEnWrData,
  input wire [1:0] extLevelMode,
  input wire [9:0] wakeIrq,
  input wire sysResetReq,
  input wire [7:0] clkEnable,
  input wire brownoutEn,
  input wire brownoutSleepOffBit,
  input wire adcAutoStart,
  input wire coreStall,
  input wire sleeping,
  input wire [2:0] activeMode
);
  reg [2:0] armAge_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // cycles since the unlock strobe, saturating so old unlocks expire
  always @(posedge core_clk) begin
    if (!nrst) armAge_r <= 3'h7;
    else if (bodsWrStb && bodsEnWrData && bodsWrData) armAge_r <= 3'h0;
    else if (armAge_r != 3'h7) armAge_r <= armAge_r + 3'h1;
  end
  sequence s_take;
    sleepInstr && sleepEnableBit && !coreStall;
  endsequence
  sequence s_arm;
    bodsWrStb && bodsEnWrData && bodsWrData;
  endsequence
  property p_no_enable;
    sleepInstr && !sleepEnableBit && !coreStall |=> !coreStall;
  endproperty
  property p_reserved;
    s_take ##0 sleepKindField[2:1] == 2'b10 |=> !coreStall ##1 !sleeping;
  endproperty
  property p_idle_gate;
    s_take ##0 sleepKindField == 3'h0 |=> coreStall ##1 sleeping && clkEnable[6:0] == 7'h7c;
  endproperty
  property p_pdown_gate;
    s_take ##0 sleepKindField == 3'h2 |=> coreStall ##1 sleeping && clkEnable == 8'h00;
  endproperty
  property p_adc_start;
    adcAutoStart |-> sleeping && activeMode[2:1] == 2'b00 && adcEnabled;
  endproperty
  property p_wake;
    sleeping && wakeIrq[6] |=> !sleeping ##1 clkEnable == 8'hff;
  endproperty
  // detector must be back on once the wake has started
  property p_bod_back;
    $fell(sleeping) |=> brownoutEn;
  endproperty
  // edge requests and other serial events must not end deep sleep
  property p_edge_ignored;
    sleeping && activeMode != 3'h0 && extLevelMode == 2'b00 && !sysResetReq &&
      (wakeIrq == 10'h001 || wakeIrq == 10'h100) |=> sleeping;
  endproperty
  property p_brownout_sleep_off_bit_locked;
    bodsWrStb && !bodsEnWrData && armAge_r > 3'h3 |=> $stable(brownoutSleepOffBit);
  endproperty
  property p_brownout_sleep_off_bit_write;
    s_arm ##1 bodsWrStb && !bodsEnWrData |=> brownoutSleepOffBit == $past(bodsWrData);
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("sleep without enable");
  a_reserved: assert property (p_reserved) else $error("reserved code slept");
  a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");
  a_pdown_gate: assert property (p_pdown_gate) else $error("power-down gating wrong");
  a_adc_start: assert property (p_adc_start) else $error("stray conversion start");
  a_wake: assert property (p_wake) else $error("watchdog wake missed");
  a_edge_ignored: assert property (p_edge_ignored) else $error("bad wake source");
  a_brownout_sleep_off_bit_locked: assert property (p_brownout_sleep_off_bit_locked) else $error("locked write taken");
  a_brownout_sleep_off_bit_write: assert property (p_brownout_sleep_off_bit_write) else $error("unlocked write lost");
  a_bod_back: assert property (p_bod_back) else $error("detector not back on");
endmodule
bind sleep_mode_power_controller sleep_ctrl_chk u_chk (
  .core_clk(core_clk), .nrst(nrst), .sleepInstr(sleepInstr), .sleepEnableBit(sleepEnableBit),
  .sleepKindField(sleepKindField), .adcEnabled(adcEnabled), .bodsWrStb(bodsWrStb),
  .bodsWrData(bodsWrData), .bodsEnWrData(bodsEnWrData), .extLevelMode(extLevelMode),
  .wakeIrq(wakeIrq), .sysResetReq(sysResetReq), .clkEnable(clkEnable), .brownoutEn(brownoutEn),
  .brownoutSleepOffBit(brownoutSleepOffBit), .adcAutoStart(adcAutoStart),
  .coreStall(coreStall), .sleeping(sleeping), .activeMode(activeMode)
);

// [bench/core_model.sv]
/* core-side partner: sleep instruction and timed off-bit write
   assumes the bench calls one task at a time */
`timescale 1ns/100ps
module core_model (
  input wire core_clk,
  input wire coreStall,
  output reg sleepInstr,
  output reg sleepEnableBit,
  output reg [2:0] sleepKindField,
  output reg bodsWrStb,
  output reg bodsWrData,
  output reg bodsEnWrData
);
  // quiet core at time zero
  initial begin
    {sleepInstr, sleepEnableBit, sleepKindField} = 5'h00;
    {bodsWrStb, bodsWrData, bodsEnWrData} = 3'h0;
  end
  // enable bit first, then one sleep cycle once the core runs
  task sleep_op(input logic en, input logic [2:0] kind);
    @(posedge core_clk);
    #1 sleepEnableBit = en;
    sleepKindField = kind;
    while (coreStall) #10;
    @(posedge core_clk);
    #1 sleepInstr = 1'b1;
    @(posedge core_clk);
    #1 sleepInstr = 1'b0;
    sleepEnableBit = 1'b0;
  endtask
  // unlock then write; data inverted once released
  task brownout_sleep_off_bit_write(input logic arm, input logic v);
    if (arm) begin
      @(posedge core_clk);
      #1 {bodsWrStb, bodsEnWrData, bodsWrData} = 3'b111;
    end
    @(posedge core_clk);
    #1 {bodsWrStb, bodsEnWrData, bodsWrData} = {2'b10, v};
    @(posedge core_clk);
    #1 {bodsWrStb, bodsWrData} = {1'b0, !v};
  endtask
endmodule

// [bench/sleep_mode_power_controller_tb.sv]
/* bench of the sleep controller: core model, wake stimulus, noted
   results checked by an output watcher; short start-up counts */
`timescale 1ns/100ps
module sleep_mode_power_controller_tb;
  localparam int SU = 8;
  localparam int BW = 20;
  logic core_clk = 1'b0, nrst = 1'b0, bodsSet = 1'b0, wasSleep = 1'b0;
  logic entered = 1'b0, startSeen = 1'b0;
  logic crystalSelected = 1'b1, adcEnabled = 1'b0, timer2Async = 1'b1, touchEnabled = 1'b0;
  logic brownoutFusesOn = 1'b1, extIrqPinA = 1'b1, extIrqPinB = 1'b1, sysResetReq = 1'b0;
  logic [1:0] extLevelMode = 2'b00;
  logic [9:0] wakeIrq = 10'h000;
  wire sleepInstr, sleepEnableBit, bodsWrStb, bodsWrData, bodsEnWrData, brownoutEn;
  wire brownoutSleepOffBit, adcAutoStart, coreStall, resumeIrq, resumeReset, sleeping;
  wire [2:0] sleepKindField, activeMode;
  wire [7:0] clkEnable;
  logic [9:0] expQ[$];
  int n_errors = 0, checks = 0, lat = 0;
  logic [2:0] mt[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h3, 3'h2};
  logic [9:0] rt[8] = '{10'h0, 10'h301, 10'h1, 10'h330, 10'h100, 10'h330, 10'h8, 10'h0};
  logic [9:0] wt[8] = '{10'h200, 10'h20, 10'h4, 10'h8, 10'h80, 10'h8, 10'h2, 10'h0};
  sleep_mode_power_controller #(.STARTUP_CYC(SU), .BOD_WAKE_CYC(BW))
    u_sleep_mode_power_controller (
    .core_clk(core_clk), .nrst(nrst), .sleepInstr(sleepInstr), .sleepEnableBit(sleepEnableBit),
    .sleepKindField(sleepKindField), .crystalSelected(crystalSelected),
    .adcEnabled(adcEnabled), .timer2Async(timer2Async), .touchEnabled(touchEnabled),
    .brownoutFusesOn(brownoutFusesOn), .bodsWrStb(bodsWrStb), .bodsWrData(bodsWrData),
    .bodsEnWrData(bodsEnWrData), .extIrqPinA(extIrqPinA), .extIrqPinB(extIrqPinB),
    .extLevelMode(extLevelMode), .wakeIrq(wakeIrq), .sysResetReq(sysResetReq),
    .clkEnable(clkEnable), .brownoutEn(brownoutEn), .brownoutSleepOffBit(brownoutSleepOffBit),
    .adcAutoStart(adcAutoStart), .coreStall(coreStall), .resumeIrq(resumeIrq),
    .resumeReset(resumeReset), .sleeping(sleeping), .activeMode(activeMode)
  );
  core_model u_core_model (
    .core_clk(core_clk), .coreStall(coreStall), .sleepInstr(sleepInstr),
    .sleepEnableBit(sleepEnableBit), .sleepKindField(sleepKindField), .bodsWrStb(bodsWrStb),
    .bodsWrData(bodsWrData), .bodsEnWrData(bodsEnWrData)
  );
  initial forever #5 core_clk = !core_clk;
  task give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task take(input logic [9:0] got);
    if (expQ.size() == 0) chk(got, 10'h3ff);
    else chk(got, expQ.pop_front());
  endtask
  function automatic logic [7:0] gate(input logic [2:0] m);
    logic [7:0] g;
    case (m)
      3'h0: g = 8'h7c;
      3'h1: g = 8'h78;
      3'h3: g = {1'b0, touchEnabled, 6'h30};
      3'h6: g = 8'h40;
      3'h7: g = {3'b011, timer2Async, 4'h0}; // async domain only with timer 2 async
      default: g = 8'h00;
    endcase
    g[7] = timer2Async && (m == 3'h0 || m == 3'h1 || m == 3'h3 || m == 3'h7);
    return g;
  endfunction
  function automatic logic bodOn(input logic [2:0] m);
    return !(bodsSet && brownoutFusesOn && m != 3'h0 && m != 3'h1);
  endfunction
  // sleep, offer a refused source, then wake: code 0 = level pin, 3ff = reset
  task cycle(input logic [2:0] m, input logic [9:0] rej, input logic [9:0] wk);
    int l;
    logic a;
    a = 1'($urandom % 2);
    l = (m == 3'h0) ? 1 : (m[2:1] == 2'b11) ? 6 : SU;
    if (!bodOn(m)) l = BW;
    adcEnabled = a;
    expQ.push_back({a && m < 3'h2, bodOn(m), gate(m)});
    expQ.push_back({wk == 10'h3ff, 9'(wk == 10'h3ff ? l : l + 4)});
    u_core_model.sleep_op(1'b1, m);
    repeat (3) @(posedge core_clk);
    #1 wakeIrq = rej;
    repeat (5) @(posedge core_clk);
    #1 chk({6'h0, activeMode, sleeping}, {6'h0, m, 1'b1});
    if (wk == 10'h3ff) sysResetReq = 1'b1;
    else if (wk == 10'h000) {extLevelMode, extIrqPinA} = 3'b010;
    else wakeIrq = wk;
    for (int i = 0; i < 60 && !(resumeIrq || resumeReset); i++) @(negedge core_clk);
    @(posedge core_clk);
    #1 {wakeIrq, sysResetReq, extLevelMode, extIrqPinA} = 14'h001;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // result watcher; gating lands one cycle after sleeping rises
  always @(negedge core_clk) begin
    lat = (wasSleep && !sleeping) ? 0 : lat + 1;
    if (entered) take({startSeen, brownoutEn, clkEnable});
    entered = sleeping && !wasSleep;
    startSeen = adcAutoStart;
    if (resumeIrq || resumeReset) take({resumeReset, 9'(lat)});
    wasSleep = sleeping;
  end
  // hang guard, about thirty times the expected run
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h8807));
    repeat (2) @(posedge core_clk);
    #1 nrst = 1'b1;
    // refused: enable clear, codes 4 and 5, standby without crystal
    for (int i = 0; i < 4; i++) begin
      crystalSelected = (i != 3);
      u_core_model.sleep_op(i != 0, (i == 0) ? 3'h0 : 3'(i + 3));
      repeat (3) @(posedge core_clk);
      #1 chk({coreStall, sleeping, clkEnable}, 10'h0ff);
    end
    crystalSelected = 1'b1;
    for (int i = 0; i < 8; i++) begin
      timer2Async = (i != 6);
      touchEnabled = 1'($urandom % 2);
      cycle(mt[i], rt[i], wt[i]);
    end
    // off bit: unlocked write, then a locked one that must not land
    u_core_model.brownout_sleep_off_bit_write(1'b1, 1'b1);
    repeat (5) @(posedge core_clk);
    u_core_model.brownout_sleep_off_bit_write(1'b0, 1'b0);
    chk({9'h0, brownoutSleepOffBit}, 10'h001);
    bodsSet = 1'b1;
    cycle(3'h6, 10'h000, 10'h040);
    cycle(3'h0, 10'h000, 10'h040);
    u_core_model.brownout_sleep_off_bit_write(1'b1, 1'b0);
    bodsSet = 1'b0;
    cycle(3'h2, 10'h000, 10'h3ff);
    chk(10'(expQ.size()), 10'h000);
    give_verdict();
  end
endmodule
